// *** rtl/amps_sequencer.sv ***
// mode sequencing and protection manager of a two-channel switching power stage
// Summary of operation
// - mode input picks standby, mute or operating; the stage follows it
// - mute keeps outputs switching with input stages off; operating enables them
// - standby to mute waits 100 ms before the outputs switch
// - audio enabled only in operating and no sooner than 150 ms after leaving standby
// - standby straight to operating: switching after 100 ms, audio 50 ms later
// - start-up always passes through mute before operating
// - thermal foldback lowers gain only; no shutdown, restart or indicator
// - over-temperature shuts down at once; restart 100 ms after it clears
// - current limiting clamps the output and keeps switching
// - current limiting longer than the time constant shuts the stage down
// - indicator pin shows current limiting and overcurrent shutdown only
// - load short shuts down; restart 100 ms after it clears
// - rail short check before power stages on leaving standby; halt while present
// - restart after overcurrent shutdown repeats the rail short check
// - rail short check never shuts down; start resumes directly once clear
// - undervoltage shuts down, silently on internal clock; restart after 100 ms
// - overvoltage shuts the power stages down; restart after 100 ms
// - supply unbalance shuts down; restart 100 ms after it clears
//
// The Avalon-MM slave port and the address map were chosen for this implementation.
module amps_sequencer #(
   parameter int unsigned WAKE_CYC    = amps_pkg::WAKE_CYC,     // start-up delay
   parameter int unsigned AUDIO_CYC   = amps_pkg::AUDIO_CYC,    // audio enable delay
   parameter int unsigned RESTART_CYC = amps_pkg::RESTART_CYC,  // fault restart delay
   parameter int unsigned OC_TAU_CYC  = amps_pkg::OC_TAU_CYC,   // current limit endurance
   parameter int          TW          = 26                       // timer width
) (
   input  wire logic        clk,                 // 250 MHz core clock
   input  wire logic        rst_n,               // async reset, active low
   // decoded mode selection and monitor flags
   input  wire logic [1:0]  mode_sel,            // 0 standby, 1 mute, 2 operating
   input  wire logic        temp_fold,           // above foldback_trip_temperature
   input  wire logic        temp_shut,           // above shutdown_trip_temperature
   input  wire logic        cur_limit,           // overcurrent_guard clamping
   input  wire logic        load_short,          // below short_impedance_threshold
   input  wire logic        rail_short,          // output shorted to a supply rail
   input  wire logic        under_volt,          // supply below minimum
   input  wire logic        over_volt,           // supply above maximum
   input  wire logic        supply_unbal,        // supply_unbalance_guard trip
   input  wire logic        int_clk_sel,         // internal oscillator in use
   // power stage controls
   output logic             switch_en,           // power outputs switching
   output logic             input_stage_en,      // voltage-to-current stages on
   output logic             thermal_gain_reduction, // gain lowered by foldback
   output logic             prot_pin,            // overcurrent indicator
   output logic             silent_stop,         // pop-free switch-off in progress
   // avalon-mm slave
   input  wire logic [3:0]  avs_address,         // byte address
   input  wire logic        avs_read,            // read strobe
   input  wire logic        avs_write,           // write strobe
   input  wire logic [31:0] avs_writedata,       // write data
   input  wire logic [3:0]  avs_byteenable,      // byte lanes
   output logic [31:0]      avs_readdata,        // read data
   output logic             avs_waitrequest      // high until the access is taken
);

   // local names for the package state type and its codes
   typedef amps_pkg::amps_state_t amps_state_t;
   localparam amps_state_t ST_STBY   = amps_pkg::ST_STBY;
   localparam amps_state_t ST_WINDOW = amps_pkg::ST_WINDOW;
   localparam amps_state_t ST_WAKE   = amps_pkg::ST_WAKE;
   localparam amps_state_t ST_MUTE   = amps_pkg::ST_MUTE;
   localparam amps_state_t ST_OPER   = amps_pkg::ST_OPER;
   localparam amps_state_t ST_FAULT  = amps_pkg::ST_FAULT;

   typedef struct packed {
      amps_state_t           state;
      logic [7:0]            meta;        // first synchroniser stage
      logic [7:0]            sync;        // second synchroniser stage
      logic [TW-1:0]         cnt;         // wake and restart timer
      logic [TW-1:0]         aud_cnt;     // time since leaving standby
      logic [TW-1:0]         oc_cnt;      // length of current limiting
      logic                  restart;     // waking from a fault, skip start delay
      logic                  oc_cause;    // last shutdown from overcurrent
      logic                  uv_cause;    // last shutdown from undervoltage
      logic [1:0]            ctrl;
      logic [amps_pkg::NFLT-1:0] flog;    // sticky fault log
      logic                  ack;
      logic [31:0]           rdata;
      logic                  sw_en;
      logic                  in_en;
      logic                  gain_red;
      logic                  prot;
      logic                  silent;
   } amps_regs_t;

   amps_regs_t r_r;
   amps_regs_t r_nxt;

   // synchronised flag names
   logic s_fold, s_shut, s_clim, s_lshort, s_rail, s_uv, s_ov, s_unbal;
   logic oc_trip;
   logic shut_fault;
   logic acc;
   logic [amps_pkg::NFLT-1:0] ev;

   typedef logic [TW-1:0] amps_cnt_t;

   // flag names taken from the second synchroniser stage only
   assign {s_unbal, s_ov, s_uv, s_rail, s_lshort, s_clim, s_shut, s_fold} = r_r.sync;

   // overcurrent shutdown once limiting outlasts its time constant
   assign oc_trip    = s_clim && (r_r.oc_cnt >= amps_cnt_t'(OC_TAU_CYC));
   assign shut_fault = s_shut || oc_trip || s_lshort || s_uv || s_ov || s_unbal;

   // a bus access is answered one cycle after it appears
   assign acc             = (avs_read || avs_write) && r_r.ack;
   assign avs_waitrequest = (avs_read || avs_write) && !r_r.ack;

   // events for the fault log
   always_comb begin
      ev = '0;
      ev[amps_pkg::FLT_THERM] = s_shut;
      ev[amps_pkg::FLT_OC]    = oc_trip;
      ev[amps_pkg::FLT_SHORT] = s_lshort;
      ev[amps_pkg::FLT_UV]    = s_uv;
      ev[amps_pkg::FLT_OV]    = s_ov;
      ev[amps_pkg::FLT_UNBAL] = s_unbal;
      ev[amps_pkg::FLT_RAIL]  = s_rail && (r_r.state == ST_WINDOW);
   end

   // how the sequencer walks its states
   //
   // standby
   //    all stages off, timers cleared
   //    left as soon as the mode input
   //    asks for mute or operating and
   //    software does not hold standby
   //
   // window
   //    rail short check with the power
   //    stages still off, so no large
   //    current can flow into a short
   //    waits here as long as the short
   //    stands; never a shutdown
   //    a fresh start goes on to wake,
   //    a restart goes straight to mute
   //
   // wake
   //    start-up delay before switching
   //    counted in the shared timer
   //
   // mute
   //    outputs switch, input stages off
   //    operating is refused until the
   //    audio timer has run out, which
   //    lets the coupling caps charge
   //
   // operating
   //    input stages on unless software
   //    forces them off
   //
   // fault
   //    power stages off
   //    the restart timer is cleared by
   //    every cycle with a fault, so it
   //    only completes after a clean span
   //    an overcurrent cause passes the
   //    window check again on restart
   //
   // priorities, lowest first
   //    the case statement below
   //    then shutdown faults
   //    then standby, which always wins
   //
   // timers
   //    cnt is shared by wake and fault;
   //    the two never run together
   //    aud_cnt runs from leaving standby
   //    and keeps counting through faults,
   //    so a restart waits only for what
   //    is left of the audio delay
   //    oc_cnt times current limiting
   //    only while the outputs switch;
   //    it clears in fault, so a held
   //    limit does not stretch the wait
   //
   // indicator
   //    limiting while switching, or a
   //    shutdown whose cause was
   //    overcurrent; thermal, supply
   //    and load faults stay off it
   //
   // silent stop
   //    marks an undervoltage shutdown
   //    while the internal oscillator
   //    runs; the cause is dropped once
   //    no shutdown fault is left
   //
   // bus
   //    every access waits one cycle
   //    read data are captured in the
   //    cycle the request first shows
   //    and held until the next access
   //    writes land in the ack cycle
   //    unmapped offsets read as zero
   //
   // limitation: monitor flags reach
   // the logic two cycles late, so a
   // pulse shorter than a cycle may be
   // missed; the analog side must hold
   // its flags for at least one cycle

   // next-state logic for the whole block
   always_comb begin
      r_nxt = r_r;

      // two-flop synchronisers for every monitor flag
      r_nxt.meta = {supply_unbal, over_volt, under_volt, rail_short,
                    load_short, cur_limit, temp_shut, temp_fold};
      r_nxt.sync = r_r.meta;

      // limiting is timed only while the outputs switch
      if (s_clim && r_r.sw_en) begin
         if (r_r.oc_cnt != '1) begin
            r_nxt.oc_cnt = r_r.oc_cnt + amps_cnt_t'(1);
         end
      end else begin
         r_nxt.oc_cnt = '0;
      end

      // audio delay counts from leaving standby and saturates
      if (r_r.state != ST_STBY && r_r.aud_cnt < amps_cnt_t'(AUDIO_CYC)) begin
         r_nxt.aud_cnt = r_r.aud_cnt + amps_cnt_t'(1);
      end

      unique case (r_r.state)
         ST_STBY: begin
            r_nxt.cnt     = '0;
            r_nxt.aud_cnt = '0;
            r_nxt.restart = 1'b0;
            if (mode_sel != amps_pkg::MODE_STBY &&
                !r_r.ctrl[amps_pkg::CTRL_HOLD_STBY]) begin
               r_nxt.state = ST_WINDOW;
            end
         end
         // rail short check with the power stages still off
         ST_WINDOW: begin
            if (!s_rail) begin
               r_nxt.cnt   = '0;
               r_nxt.state = r_r.restart ? ST_MUTE : ST_WAKE;
            end
         end
         ST_WAKE: begin
            r_nxt.cnt = r_r.cnt + amps_cnt_t'(1);
            if (r_r.cnt >= amps_cnt_t'(WAKE_CYC - 1)) begin
               r_nxt.state = ST_MUTE;
            end
         end
         // switching with audio off until operating is allowed
         ST_MUTE: begin
            if (mode_sel == amps_pkg::MODE_OPER &&
                r_r.aud_cnt >= amps_cnt_t'(AUDIO_CYC)) begin
               r_nxt.state = ST_OPER;
            end
         end
         ST_OPER: begin
            if (mode_sel == amps_pkg::MODE_MUTE) begin
               r_nxt.state = ST_MUTE;
            end
         end
         // any fault restarts the wait, so the timer runs only while all clear
         ST_FAULT: begin
            if (shut_fault) begin
               r_nxt.cnt = '0;
            end else if (r_r.cnt >= amps_cnt_t'(RESTART_CYC - 1)) begin
               r_nxt.restart = 1'b1;
               r_nxt.cnt     = '0;
               r_nxt.state   = r_r.oc_cause ? ST_WINDOW : ST_MUTE;
            end else begin
               r_nxt.cnt = r_r.cnt + amps_cnt_t'(1);
            end
         end
      endcase

      // shutdown faults win over every active state
      if (r_r.state != ST_STBY && r_r.state != ST_FAULT && shut_fault) begin
         r_nxt.state    = ST_FAULT;
         r_nxt.cnt      = '0;
         r_nxt.oc_cause = oc_trip;
         r_nxt.uv_cause = s_uv;
      end
      if (r_r.state == ST_FAULT && !shut_fault) begin
         r_nxt.uv_cause = r_r.uv_cause && s_uv;
      end
      // standby always wins; window check halts without shutdown
      if (mode_sel == amps_pkg::MODE_STBY || r_r.ctrl[amps_pkg::CTRL_HOLD_STBY]) begin
         r_nxt.state    = ST_STBY;
         r_nxt.oc_cause = 1'b0;
         r_nxt.uv_cause = 1'b0;
      end

      // registered outputs follow the next state; gain reduction follows the foldback flag
      r_nxt.sw_en    = (r_nxt.state == ST_MUTE) || (r_nxt.state == ST_OPER);
      r_nxt.in_en    = (r_nxt.state == ST_OPER) &&
                       !r_r.ctrl[amps_pkg::CTRL_FORCE_MUTE];
      r_nxt.gain_red = s_fold;
      r_nxt.prot     = (s_clim && r_r.sw_en) ||
                       (r_nxt.state == ST_FAULT && r_nxt.oc_cause);
      r_nxt.silent   = (r_nxt.state == ST_FAULT) && r_nxt.uv_cause &&
                       int_clk_sel;

      // bus slave: answer one cycle after the request appears
      r_nxt.ack = (avs_read || avs_write) && !r_r.ack;
      if ((avs_read || avs_write) && !r_r.ack) begin
         unique case (avs_address)
            amps_pkg::OFS_CTRL:   r_nxt.rdata = {30'h0, r_r.ctrl};
            amps_pkg::OFS_STATUS: r_nxt.rdata = {13'h0, r_r.silent, r_r.prot,
                                                 r_r.in_en, r_r.sw_en, r_r.gain_red,
                                                 r_r.sync, r_r.state};
            amps_pkg::OFS_FAULT:  r_nxt.rdata = {25'h0, r_r.flog};
            default:              r_nxt.rdata = 32'h0;
         endcase
      end

      // control write
      if (acc && avs_write && avs_address == amps_pkg::OFS_CTRL && avs_byteenable[0]) begin
         r_nxt.ctrl = avs_writedata[1:0];
      end
      // fault log: write one to clear, a new event in the same cycle wins
      if (acc && avs_write && avs_address == amps_pkg::OFS_FAULT && avs_byteenable[0]) begin
         r_nxt.flog = r_r.flog & ~avs_writedata[amps_pkg::NFLT-1:0];
      end
      r_nxt.flog = r_nxt.flog | ev;
   end

   // single register bank for all state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_r          <= '0;
         r_r.state    <= ST_STBY;
         r_r.ctrl     <= amps_pkg::CTRL_RST;
      end else begin
         r_r <= r_nxt;
      end
   end

   // outputs straight from flops
   assign switch_en              = r_r.sw_en;
   assign input_stage_en         = r_r.in_en;
   assign thermal_gain_reduction = r_r.gain_red;
   assign prot_pin               = r_r.prot;
   assign silent_stop            = r_r.silent;
   assign avs_readdata           = r_r.rdata;

endmodule // amps_sequencer

// *** rtl/amps_pkg.sv ***
// shared constants of the amplifier mode and protection sequencer
package amps_pkg;

   // clock rate and derived rates
   localparam int unsigned CLK_KHZ       = 250000;   // 250 MHz core clock
   localparam int unsigned CLK_PER_US    = 250;

   // documented start-up and restart times
   localparam int unsigned T_WAKE_MS     = 100;      // standby to switching
   localparam int unsigned T_AUDIO_MS    = 150;      // standby to audio enable
   localparam int unsigned T_RESTART_MS  = 100;      // fault clear to restart
   localparam int unsigned T_OC_TAU_US   = 50;       // current limit endurance

   localparam int unsigned WAKE_CYC      = T_WAKE_MS * CLK_KHZ;
   localparam int unsigned AUDIO_CYC     = T_AUDIO_MS * CLK_KHZ;
   localparam int unsigned RESTART_CYC   = T_RESTART_MS * CLK_KHZ;
   localparam int unsigned OC_TAU_CYC    = T_OC_TAU_US * CLK_PER_US;

   // decoded mode selection
   localparam logic [1:0]  MODE_STBY     = 2'h0;
   localparam logic [1:0]  MODE_MUTE     = 2'h1;
   localparam logic [1:0]  MODE_OPER     = 2'h2;

   // register byte offsets
   localparam logic [3:0]  OFS_CTRL      = 4'h0;
   localparam logic [3:0]  OFS_STATUS    = 4'h4;
   localparam logic [3:0]  OFS_FAULT     = 4'h8;

   // control bits and reset value
   localparam int          CTRL_HOLD_STBY = 0;       // keep the stage in standby
   localparam int          CTRL_FORCE_MUTE = 1;      // keep input stages off
   localparam logic [1:0]  CTRL_RST      = 2'h0;

   // fault log bit positions
   localparam int          FLT_THERM     = 0;
   localparam int          FLT_OC        = 1;
   localparam int          FLT_SHORT     = 2;
   localparam int          FLT_UV        = 3;
   localparam int          FLT_OV        = 4;
   localparam int          FLT_UNBAL     = 5;
   localparam int          FLT_RAIL      = 6;
   localparam int          NFLT          = 7;

   // sequencer states, one-hot
   typedef enum logic [5:0] {
      ST_STBY   = 6'h01,
      ST_WINDOW = 6'h02,
      ST_WAKE   = 6'h04,
      ST_MUTE   = 6'h08,
      ST_OPER   = 6'h10,
      ST_FAULT  = 6'h20
   } amps_state_t;

endpackage : amps_pkg

// *** testbench/amps_mode_src.sv ***
// model of the outside circuit that drives the decoded mode input
module amps_mode_src #(
   parameter int SLEW = 16                 // cycles held in mute on a slow start
) (
   input  wire logic       clk,            // core clock
   input  wire logic       rst_n,          // async reset, active low
   input  wire logic [1:0] target,         // mode the bench asks for
   input  wire logic       slow,           // step through mute on the way up
   output logic [1:0]      mode_sel        // decoded mode level
);
   logic [7:0] cnt_r;                      // time spent in mute on the way up
   // slow starts linger in mute, which keeps the coupling caps quiet
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_sel <= amps_pkg::MODE_STBY;
         cnt_r    <= 8'h00;
      end else if (slow && target == amps_pkg::MODE_OPER && cnt_r < 8'(SLEW)) begin
         mode_sel <= amps_pkg::MODE_MUTE;
         cnt_r    <= cnt_r + 8'h01;
      end else begin
         mode_sel <= target;
         cnt_r    <= (target == amps_pkg::MODE_OPER) ? cnt_r : 8'h00;
      end
   end
endmodule // amps_mode_src

// *** testbench/amps_sequencer_chk.sv ***
// port assertions of the amplifier mode and protection sequencer
module amps_chk #(
   parameter int unsigned WAKE_CYC    = 40, // start-up delay
   parameter int unsigned AUDIO_CYC   = 60, // audio delay
   parameter int unsigned RESTART_CYC = 40  // restart delay
) (
   input wire logic       clk,              // core clock
   input wire logic       rst_n,            // async reset
   input wire logic [1:0] mode_sel,         // decoded mode
   input wire logic       temp_fold,        // foldback flag
   input wire logic       temp_shut,        // hot flag
   input wire logic       cur_limit,        // limiting flag
   input wire logic       load_short,       // load short
   input wire logic       rail_short,       // rail short
   input wire logic       under_volt,       // supply low
   input wire logic       over_volt,        // supply high
   input wire logic       supply_unbal,     // unbalance
   input wire logic       switch_en,        // switching
   input wire logic       input_stage_en,   // audio on
   input wire logic       thermal_gain_reduction, // gain lowered
   input wire logic       prot_pin          // indicator
);
   logic [15:0] run_r;                      // cycles out of standby
   logic [15:0] clr_r;                      // cycles free of shutdown faults
   wire logic   flt_any = temp_shut | load_short | under_volt | over_volt | supply_unbal;
   // saturating time bases for the start-up and restart figures
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run_r <= 16'h0000;
         clr_r <= 16'h0000;
      end else begin
         run_r <= (mode_sel == amps_pkg::MODE_STBY) ? 16'h0000 : run_r + {15'h0, ~&run_r};
         clr_r <= flt_any ? 16'h0000 : clr_r + {15'h0, ~&clr_r};
      end
   end
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_leave;
      $past(mode_sel) == amps_pkg::MODE_STBY && mode_sel != amps_pkg::MODE_STBY;
   endsequence
   sequence s_quiet;
      (!switch_en && !input_stage_en) [*8];
   endsequence
   start_quiet_a: assert property (s_leave |=> s_quiet)
      else $error("outputs woke right after standby");
   stby_off_a: assert property ((mode_sel == amps_pkg::MODE_STBY) [*2] |=>
      !switch_en && !input_stage_en) else $error("standby left stages on");
   wake_wait_a: assert property ($rose(switch_en) |-> run_r >= WAKE_CYC)
      else $error("switching began too soon");
   audio_wait_a: assert property ($rose(input_stage_en) |->
      run_r >= AUDIO_CYC && switch_en) else $error("audio enabled too soon");
   audio_mode_a: assert property (input_stage_en |->
      $past(mode_sel, 2) == amps_pkg::MODE_OPER) else $error("audio on outside operating");
   fold_gain_a: assert property (temp_fold [*5] |-> thermal_gain_reduction)
      else $error("no gain reduction when hot");
   prot_cause_a: assert property ($rose(prot_pin) |-> cur_limit || $past(cur_limit) ||
      $past(cur_limit, 2) || $past(cur_limit, 3) || $past(cur_limit, 4))
      else $error("indicator without limiting");
   hot_stop_a: assert property (temp_shut [*7] |-> !switch_en)
      else $error("no shutdown when too hot");
   restart_wait_a: assert property ($rose(switch_en) |-> clr_r >= RESTART_CYC)
      else $error("restart before delay");
   window_hold_a: assert property ((rail_short && !switch_en && run_r < 16'h0400) [*4]
      |=> !switch_en) else $error("started into a rail short");
endmodule // amps_chk

bind amps_sequencer amps_chk #(.WAKE_CYC(WAKE_CYC), .AUDIO_CYC(AUDIO_CYC),
   .RESTART_CYC(RESTART_CYC)) chk_u (.clk, .rst_n, .mode_sel, .temp_fold, .temp_shut,
   .cur_limit, .load_short, .rail_short, .under_volt, .over_volt, .supply_unbal,
   .switch_en, .input_stage_en, .thermal_gain_reduction, .prot_pin);

// *** testbench/amps_sequencer_tb_top.sv ***
// self-checking bench of the amplifier mode and protection sequencer
module amps_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned WK = 40, AU = 60, RS = 40, OC = 8;
   localparam int FB[5] = '{amps_pkg::FLT_THERM, amps_pkg::FLT_SHORT, amps_pkg::FLT_UV,
                            amps_pkg::FLT_OV, amps_pkg::FLT_UNBAL};
   logic        clk = 1'b0, rst_n = 1'b0, slow = 1'b0;
   logic [1:0]  target = 2'h0, mode_sel;
   logic        temp_fold = 1'b0, cur_limit = 1'b0, rail_short = 1'b0, int_clk_sel = 1'b1;
   logic [4:0]  flt = 5'h00;
   logic        switch_en, input_stage_en, thermal_gain_reduction, prot_pin, silent_stop;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   int          n_errors = 0, checks_done = 0, n, m;
   amps_sequencer #(.WAKE_CYC(WK), .AUDIO_CYC(AU), .RESTART_CYC(RS), .OC_TAU_CYC(OC))
      dut_u (.clk, .rst_n, .mode_sel, .temp_fold, .temp_shut(flt[0]), .cur_limit,
             .load_short(flt[1]), .rail_short, .under_volt(flt[2]), .over_volt(flt[3]),
             .supply_unbal(flt[4]), .int_clk_sel, .switch_en, .input_stage_en,
             .thermal_gain_reduction, .prot_pin, .silent_stop, .avs_address, .avs_read,
             .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
             .avs_waitrequest);
   amps_mode_src #(.SLEW(16)) src_u (.clk, .rst_n, .target, .slow, .mode_sel);
   // 250 MHz core clock
   always #2 clk = ~clk;
   task automatic summarize();
      if (n_errors == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one bus access; the request stands until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int t;
      t = 0;
      avs_read <= !w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= d;
      do begin
         @(posedge clk);
         t++;
      end while (avs_waitrequest !== 1'b0 && t < 20);
      q = avs_readdata;
      if (t >= 20) n_errors++;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   // bounded wait for switching (s=0) or audio (s=1) to reach level v
   task automatic wt(input bit s, input logic v, input int lim);
      n = 0;
      while ((s ? input_stage_en : switch_en) !== v && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask
   // watchdog well beyond the several hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      summarize();
   end
   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rdc(amps_pkg::OFS_CTRL, 32'h0);
      rdc(amps_pkg::OFS_STATUS, 32'h1);
      bus(1'b1, 4'hC, 32'hFF);
      rdc(4'hC, 32'h0);
      target <= amps_pkg::MODE_OPER;
      wt(1'b0, 1'b1, WK + 20);
      m = n;
      chk(n >= WK && n <= WK + 10, 1'b1);
      chk(input_stage_en, 1'b0);
      wt(1'b1, 1'b1, AU);
      chk(m + n >= AU && m + n <= AU + 10, 1'b1);
      rdc(amps_pkg::OFS_STATUS, 32'h18010);
      target <= amps_pkg::MODE_MUTE;
      repeat (6) @(posedge clk);
      chk({switch_en, input_stage_en}, 2'b10);
      temp_fold <= 1'b1;
      repeat (6) @(posedge clk);
      chk({thermal_gain_reduction, switch_en, prot_pin}, 3'b110);
      temp_fold <= 1'b0;
      cur_limit <= 1'b1;
      repeat (4) @(posedge clk);
      chk({prot_pin, switch_en}, 2'b11);
      cur_limit <= 1'b0;
      repeat (8) @(posedge clk);
      cur_limit <= 1'b1;
      repeat (OC + 12) @(posedge clk);
      chk({prot_pin, switch_en}, 2'b10);
      cur_limit <= 1'b0;
      wt(1'b0, 1'b1, RS + WK + 20);
      chk(n + OC + 12 >= RS && switch_en, 1'b1);
      rdc(amps_pkg::OFS_FAULT, 32'h2);
      bus(1'b1, amps_pkg::OFS_FAULT, 32'h2);
      rdc(amps_pkg::OFS_FAULT, 32'h0);
      for (int i = 0; i < 5; i++) begin
         flt <= 5'h01 << i;
         repeat (10) @(posedge clk);
         chk({switch_en, prot_pin, silent_stop}, {2'b00, i == 2});
         flt <= 5'h00;
         wt(1'b0, 1'b1, RS + 20);
         chk(n >= RS && n <= RS + 10, 1'b1);
         rdc(amps_pkg::OFS_FAULT, 32'h1 << FB[i]);
         bus(1'b1, amps_pkg::OFS_FAULT, 32'h7F);
      end
      target <= amps_pkg::MODE_STBY;
      repeat (6) @(posedge clk);
      chk({switch_en, input_stage_en}, 2'b00);
      rail_short <= 1'b1;
      slow <= 1'b1;
      target <= amps_pkg::MODE_OPER;
      repeat (WK + 20) @(posedge clk);
      chk({switch_en, prot_pin}, 2'b00);
      rdc(amps_pkg::OFS_STATUS, 32'h402);
      rail_short <= 1'b0;
      wt(1'b0, 1'b1, WK + 20);
      chk(n <= WK + 10, 1'b1);
      wt(1'b1, 1'b1, AU);
      chk(input_stage_en, 1'b1);
      bus(1'b1, amps_pkg::OFS_CTRL, 32'h2);
      repeat (4) @(posedge clk);
      chk({switch_en, input_stage_en}, 2'b10);
      rdc(amps_pkg::OFS_CTRL, 32'h2);
      summarize();
   end
endmodule // amps_sequencer_tb_top
